// ### rtl/clk_mod_pkg.sv
// Shared constants for on-demand clock modulation and thermal status
package clk_mod_pkg;
  // Register select codes on the model-specific register port
  localparam logic SEL_MOD_CTRL = 1'b0;
  localparam logic SEL_THERM_STATUS = 1'b1;
  // Modulation control register fields
  localparam int MOD_EXT_BIT = 0;
  localparam int MOD_DUTY_LO = 1;
  localparam int MOD_DUTY_HI = 3;
  localparam int MOD_EN_BIT = 4;
  localparam logic [4:0] MOD_CTRL_RESET = 5'h02;
  localparam logic [3:0] DEFAULT_CODE4 = 4'h2;
  // Thermal status register fields
  localparam int TS_HOT_BIT = 0;
  localparam int TS_HOT_LOG_BIT = 1;
  localparam int TS_AGENT_BIT = 2;
  localparam int TS_CRIT_BIT = 4;
  localparam int TS_READ_LO = 16;
  localparam int TS_READ_HI = 22;
  localparam logic TS_HOT_LOG_RESET = 1'b0;
  localparam logic [6:0] TS_READ_RESET = 7'h00;
  // Capability bits
  localparam int CAP_THERM_REGS_BIT = 22;
  localparam int CAP_AUTO_TM_BIT = 29;
  localparam int CAP6_SENSOR_BIT = 0;
  localparam int CAP6_EXT_BIT = 5;
  // Modulation period
  localparam int MOD_SLOTS = 16;
  localparam logic [3:0] SLOT_RESET = 4'h0;
endpackage

// ### rtl/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      level_out <= '0;
    else
      for (int i = 0; i < WIDTH; i++)
        if (s2_r[i] == s3_r[i])
          level_out[i] <= s3_r[i];
  end
endmodule

// ### rtl/stop_slot_gen.sv
// Slot counter that turns a duty code into a stop-clock request
`timescale 1ns/100ps
module stop_slot_gen
  import clk_mod_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic active,
  input wire logic [3:0] stop_slots,
  output logic stop_req
);
  logic [3:0] slot_r;

  // Free-running period of MOD_SLOTS slots
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      slot_r <= SLOT_RESET;
    else if (slot_r == 4'(MOD_SLOTS - 1))
      slot_r <= SLOT_RESET;
    else
      slot_r <= slot_r + 4'h1;
  end

  // Stop for the first stop_slots slots of each period
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      stop_req <= 1'b0;
    else
      stop_req <= active && (slot_r < stop_slots);
  end
endmodule

// ### rtl/clock_modulation.sv
// On-demand clock modulation, thermal status and capability reporting
`timescale 1ns/100ps
module clock_modulation
  import clk_mod_pkg::*;
#(
  parameter int NUM_LP = 2,
  parameter bit EXT_PRESENT = 1'b1,
  parameter bit SENSOR_PRESENT = 1'b1,
  parameter logic [3:0] NUM_THRESH = 4'h2,
  localparam int LPW = (NUM_LP > 1) ? $clog2(NUM_LP) : 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Model-specific register port
  input wire logic msr_wr,
  input wire logic msr_rd,
  input wire logic msr_sel,
  input wire logic [LPW-1:0] msr_lp,
  input wire logic [63:0] msr_wdata,
  output logic [63:0] msr_rdata,
  output logic msr_ack,
  // Thermal monitor one
  input wire logic tm1_enable,
  input wire logic [3:0] tm1_duty,
  // Sensor and platform pins
  input wire logic sensor_hot_pin,
  input wire logic agent_hot_pin,
  input wire logic crit_temp_pin,
  input wire logic [6:0] sensor_readout,
  // Internal stop-clock request
  output logic stop_clk_req,
  // Capability reporting
  output logic [31:0] cap_feature_flags,
  output logic [31:0] cap_leaf6_eax,
  output logic [31:0] cap_leaf6_ebx
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  // Register copies and status state
  logic [4:0] mod_r [NUM_LP];
  logic hot_log_r;
  logic [6:0] readout_r;

  // Synchronised pin levels
  logic [2:0] pin_level;
  logic hot_lvl;
  logic agent_lvl;
  logic crit_lvl;

  // Modulation selection
  logic sw_active;
  logic [3:0] sw_code;
  logic tm1_hot;
  logic mod_active_r;
  logic mod_active_nxt;
  logic [3:0] mod_code_r;
  logic [3:0] mod_code_nxt;
  logic stop_raw;

  // Register port decode and read path
  logic ctrl_wr;
  logic log_clr;
  logic lp_ok;
  logic [63:0] status_word;
  logic [63:0] rdata_nxt;

  // Pin levels in the order they enter the synchroniser
  assign hot_lvl = pin_level[0];
  assign agent_lvl = pin_level[1];
  assign crit_lvl = pin_level[2];
  assign lp_ok = (int'(msr_lp) < NUM_LP);

  // Write strobes; a control write to an absent processor copy does nothing
  assign ctrl_wr = msr_wr && (msr_sel == SEL_MOD_CTRL) && lp_ok;
  assign log_clr = msr_wr && (msr_sel == SEL_THERM_STATUS) && !msr_wdata[TS_HOT_LOG_BIT];

  // Thermal monitor one claims the clock while it is enabled and hot
  assign tm1_hot = tm1_enable && hot_lvl;

  // Stop-slot count from one control register
  // Without the extension bit 0 reads as zero, so a 3-bit code counts double
  function automatic logic [3:0] code_of(input logic [4:0] v);
    logic [3:0] c;
    c = {v[MOD_DUTY_HI:MOD_DUTY_LO], EXT_PRESENT ? v[MOD_EXT_BIT] : 1'b0};
    if (c == 4'h0)
      c = DEFAULT_CODE4;
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; these pins come from outside this clock, so each
  // passes four flops and a change counts once two stages agree
  pin_sync3 #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in({crit_temp_pin, agent_hot_pin, sensor_hot_pin}),
    .level_out(pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per logical processor control registers
  // Each logical processor owns one copy; the index picks which one
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_LP; i++)
        mod_r[i] <= MOD_CTRL_RESET;
    end
    else if (ctrl_wr)
    begin
      for (int i = 0; i < NUM_LP; i++)
        if (int'(msr_lp) == i)
        begin
          mod_r[i][MOD_EN_BIT] <= msr_wdata[MOD_EN_BIT];
          mod_r[i][MOD_DUTY_HI:MOD_DUTY_LO] <= msr_wdata[MOD_DUTY_HI:MOD_DUTY_LO];
          // Reserved without the extension; stays zero
          mod_r[i][MOD_EXT_BIT] <= EXT_PRESENT ? msr_wdata[MOD_EXT_BIT] : 1'b0;
        end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal status log and readout
  // A hot event in the cycle of a clear wins, so no event goes unlogged
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hot_log_r <= TS_HOT_LOG_RESET;
    else if (hot_lvl)
      hot_log_r <= 1'b1; // set wins over clear
    else if (log_clr)
      hot_log_r <= 1'b0;
  end

  // Readout is relative to the activation point, so never above it
  // The readout comes from logic on this clock and needs no synchroniser
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      readout_r <= TS_READ_RESET;
    else
      readout_r <= sensor_readout;
  end

  // Status word assembly; unlisted bits read zero
  // Bits 3, 5 to 15 and those above the readout are not kept here
  always_comb
  begin
    status_word = '0;
    status_word[TS_HOT_BIT] = hot_lvl;
    status_word[TS_HOT_LOG_BIT] = hot_log_r;
    status_word[TS_AGENT_BIT] = agent_lvl;
    status_word[TS_CRIT_BIT] = crit_lvl;
    status_word[TS_READ_HI:TS_READ_LO] = readout_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  // A read of an absent processor copy returns zero
  always_comb
  begin
    rdata_nxt = '0;
    if (msr_sel == SEL_THERM_STATUS)
      rdata_nxt = status_word;
    else
    begin
      for (int i = 0; i < NUM_LP; i++)
        if (int'(msr_lp) == i)
          rdata_nxt[4:0] = mod_r[i];
    end
  end

  // Acknowledge one cycle after every request, out-of-range index included,
  // so that software never waits on an answer that will not come
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      msr_ack <= 1'b0;
    else
      msr_ack <= msr_wr | msr_rd;
  end

  // Read data with the acknowledge, held until the next read
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      msr_rdata <= '0;
    else if (msr_rd)
      msr_rdata <= rdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Merge of logical processors: highest duty among enabled copies
  // Copies with the enable clear are left out; software is expected to
  // enable every copy, so this matters only while it is being set up
  always_comb
  begin
    sw_active = 1'b0;
    sw_code = 4'h0;
    for (int i = 0; i < NUM_LP; i++)
      if (mod_r[i][MOD_EN_BIT])
      begin
        sw_active = 1'b1;
        if (code_of(mod_r[i]) > sw_code)
          sw_code = code_of(mod_r[i]);
      end
  end

  // Thermal monitor takes precedence while hot
  // Its duty is used as given, so a duty of zero stops nothing
  always_comb
  begin
    if (tm1_hot)
    begin
      mod_active_nxt = 1'b1;
      mod_code_nxt = tm1_duty;
    end
    else
    begin
      mod_active_nxt = sw_active;
      mod_code_nxt = sw_code;
    end
  end

  // Registered selection
  // One stage keeps the merge off the compare path; the cycle it costs
  // is far below one modulation period
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mod_active_r <= 1'b0;
      mod_code_r <= 4'h0;
    end
    else
    begin
      mod_active_r <= mod_active_nxt;
      mod_code_r <= mod_code_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot generator and internal stop-clock output
  // The counter runs freely, so a new duty starts at the next slot and
  // the period in which it changes may stop once for a mixed count
  stop_slot_gen u_slots (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .active(mod_active_r),
    .stop_slots(mod_code_r),
    .stop_req(stop_raw)
  );

  // Internal stop-clock only; the external stop pin is not involved
  // The extra flop delays the gate request one cycle; the compare is already registered in stop_slot_gen
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      stop_clk_req <= 1'b0;
    else
      stop_clk_req <= stop_raw;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feature flags, constant after reset: thermal registers and monitor present
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cap_feature_flags <= '0;
    else
    begin
      cap_feature_flags <= '0;
      cap_feature_flags[CAP_THERM_REGS_BIT] <= 1'b1;
      cap_feature_flags[CAP_AUTO_TM_BIT] <= 1'b1;
    end
  end

  // Power leaf, first word: sensor and four-bit extension support
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cap_leaf6_eax <= '0;
    else
    begin
      cap_leaf6_eax <= '0;
      cap_leaf6_eax[CAP6_SENSOR_BIT] <= SENSOR_PRESENT;
      cap_leaf6_eax[CAP6_EXT_BIT] <= EXT_PRESENT;
    end
  end

  // Power leaf, second word: usable thresholds, zero without a sensor
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cap_leaf6_ebx <= '0;
    else
    begin
      cap_leaf6_ebx <= '0;
      cap_leaf6_ebx[3:0] <= SENSOR_PRESENT ? NUM_THRESH : 4'h0;
    end
  end
endmodule

// ### sim/clock_modulation_sva.sv
// Port assertions for the clock modulation block
`timescale 1ns/100ps
module clock_modulation_sva #(
  parameter bit EXT_PRESENT = 1'b1,
  parameter bit SENSOR_PRESENT = 1'b1,
  parameter logic [3:0] NUM_THRESH = 4'h2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic msr_wr,
  input wire logic msr_rd,
  input wire logic msr_sel,
  input wire logic [63:0] msr_rdata,
  input wire logic msr_ack,
  input wire logic sensor_hot_pin,
  input wire logic crit_temp_pin,
  input wire logic [6:0] sensor_readout,
  input wire logic stop_clk_req,
  input wire logic [31:0] cap_feature_flags,
  input wire logic [31:0] cap_leaf6_eax,
  input wire logic [31:0] cap_leaf6_ebx
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [4:0] high_run_r;
  ////////////////////////////////////////
  // Length of the current stop run
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      high_run_r <= 5'h00;
    else
      high_run_r <= stop_clk_req ? high_run_r + 5'h01 : 5'h00;
  AST_STOP_RUN: assert property (high_run_r <= 5'h0f)
    else $error("stop request longer than one period");
  AST_ACK_AFTER: assert property ((msr_wr || msr_rd) |=> msr_ack)
    else $error("no ack after request");
  AST_ACK_ONLY: assert property (!(msr_wr || msr_rd) |=> !msr_ack)
    else $error("ack without request");
  AST_CAP_FLAGS: assert property ($past(rst_n) |-> cap_feature_flags == 32'h2040_0000)
    else $error("feature flags wrong");
  AST_LEAF6: assert property ($past(rst_n) |->
    cap_leaf6_eax == {26'h0, EXT_PRESENT, 4'h0, SENSOR_PRESENT} &&
    cap_leaf6_ebx == {28'h0, SENSOR_PRESENT ? NUM_THRESH : 4'h0})
    else $error("leaf six words wrong");
  AST_CTRL_ZERO: assert property (msr_rd && !msr_sel |=> msr_rdata[63:5] == 59'h0)
    else $error("control upper bits not zero");
  AST_READOUT: assert property ($past(rst_n) && msr_rd && msr_sel &&
    $stable(sensor_readout) |=> msr_rdata[22:16] == $past(sensor_readout, 2))
    else $error("readout field wrong");
  AST_HOT_BIT: assert property ((rst_n && $stable(sensor_hot_pin))[*8] ##0
    (msr_rd && msr_sel) |=> msr_rdata[0] == $past(sensor_hot_pin))
    else $error("hot status bit wrong");
  AST_CRIT_BIT: assert property ((rst_n && $stable(crit_temp_pin))[*8] ##0
    (msr_rd && msr_sel) |=> msr_rdata[4] == $past(crit_temp_pin))
    else $error("critical status bit wrong");
  // Main scenarios reached
  cover property (msr_wr && !msr_sel);
  cover property ($rose(stop_clk_req));
  cover property (msr_rd && msr_sel && sensor_hot_pin);
endmodule
bind clock_modulation clock_modulation_sva #(
  .EXT_PRESENT(EXT_PRESENT),
  .SENSOR_PRESENT(SENSOR_PRESENT),
  .NUM_THRESH(NUM_THRESH)
) sva_u (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .msr_wr(msr_wr),
  .msr_rd(msr_rd),
  .msr_sel(msr_sel),
  .msr_rdata(msr_rdata),
  .msr_ack(msr_ack),
  .sensor_hot_pin(sensor_hot_pin),
  .crit_temp_pin(crit_temp_pin),
  .sensor_readout(sensor_readout),
  .stop_clk_req(stop_clk_req),
  .cap_feature_flags(cap_feature_flags),
  .cap_leaf6_eax(cap_leaf6_eax),
  .cap_leaf6_ebx(cap_leaf6_ebx)
);

// ### sim/tb_clock_modulation.sv
// Self-checking bench for on-demand clock modulation
`timescale 1ns/100ps
module tb_clock_modulation
  import clk_mod_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n, msr_wr, msr_rd, msr_sel, msr_ack, stop_clk_req, tm1_enable;
  logic sensor_hot_pin, agent_hot_pin, crit_temp_pin;
  logic [0:0] msr_lp;
  logic [63:0] msr_wdata, msr_rdata, rd_data;
  logic [3:0] tm1_duty;
  logic [6:0] sensor_readout;
  logic [31:0] cap_feature_flags, cap_leaf6_eax, cap_leaf6_ebx;
  logic [63:0] ctrl_val [2];
  int num_errors = 0;
  int checked = 0;
  int stops;
  clock_modulation dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .msr_wr(msr_wr),
    .msr_rd(msr_rd),
    .msr_sel(msr_sel),
    .msr_lp(msr_lp),
    .msr_wdata(msr_wdata),
    .msr_rdata(msr_rdata),
    .msr_ack(msr_ack),
    .tm1_enable(tm1_enable),
    .tm1_duty(tm1_duty),
    .sensor_hot_pin(sensor_hot_pin),
    .agent_hot_pin(agent_hot_pin),
    .crit_temp_pin(crit_temp_pin),
    .sensor_readout(sensor_readout),
    .stop_clk_req(stop_clk_req),
    .cap_feature_flags(cap_feature_flags),
    .cap_leaf6_eax(cap_leaf6_eax),
    .cap_leaf6_ebx(cap_leaf6_ebx)
  );
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  // Compare one value and count it
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One register access; result taken after the ack edge
  task automatic access(logic wr, logic sel, logic lp, logic [63:0] data);
    @(negedge clk_sys);
    msr_wr = wr;
    msr_rd = !wr;
    msr_sel = sel;
    msr_lp = lp;
    msr_wdata = data;
    @(negedge clk_sys);
    rd_data = msr_rdata;
    chk("ack", 64'h1, {63'h0, msr_ack});
    msr_wr = 1'b0;
    msr_rd = 1'b0;
    msr_wdata = 64'($urandom);
  endtask
  task automatic set_ctrl(logic lp, logic [63:0] v);
    access(1'b1, SEL_MOD_CTRL, lp, v);
    ctrl_val[lp] = v;
  endtask
  // Stop slots per period that a control value asks for
  function automatic int slots(logic [63:0] v);
    if (!v[4])
      return 0;
    return (v[3:0] == 4'h0) ? 2 : int'(v[3:0]);
  endfunction
  function automatic int exp_max();
    return (slots(ctrl_val[0]) > slots(ctrl_val[1])) ? slots(ctrl_val[0]) : slots(ctrl_val[1]);
  endfunction
  // Count stop cycles over two periods after settling
  task automatic count_stops(int exp);
    stops = 0;
    repeat (8) @(negedge clk_sys);
    repeat (32)
    begin
      @(negedge clk_sys);
      if (stop_clk_req === 1'b1)
        stops++;
    end
    chk("stop slots", 64'(exp * 2), 64'(stops));
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hang
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    finish_test;
  end
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst_n, msr_wr, msr_rd, msr_sel, msr_lp, msr_wdata, tm1_duty} = '0;
    {sensor_hot_pin, agent_hot_pin, crit_temp_pin, sensor_readout} = '0;
    tm1_enable = 1'b1;
    void'($urandom(19));
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      access(1'b0, SEL_MOD_CTRL, i[0], 64'h0);
      chk("ctrl reset", 64'h2, rd_data);
      ctrl_val[i] = 64'h2;
    end
    chk("flags", 64'h2040_0000, 64'(cap_feature_flags));
    chk("leaf6 eax", 64'h21, 64'(cap_leaf6_eax));
    chk("leaf6 ebx", 64'h2, 64'(cap_leaf6_ebx));
    count_stops(0);
    set_ctrl(1'b0, 64'h0e);
    count_stops(0);
    // Both copies enabled from here on; the other one holds the smallest duty
    set_ctrl(1'b1, 64'h11);
    // Every legal four-bit code, junk in the upper bits; 0000 is never written
    for (int c = 1; c < 16; c++)
    begin
      set_ctrl(1'b0, {$urandom, 27'h0, 1'b1, c[3:0]});
      access(1'b0, SEL_MOD_CTRL, 1'b0, 64'h0);
      chk("ctrl readback", {59'h0, 1'b1, c[3:0]}, rd_data);
      count_stops(exp_max());
    end
    repeat (6)
    begin
      set_ctrl(1'b0, 64'($urandom_range(15, 1)) | 64'h10);
      set_ctrl(1'b1, 64'($urandom_range(15, 1)) | 64'h10);
      count_stops(exp_max());
    end
    // Hot sensor: monitor duty wins, log survives a clear while hot
    tm1_duty = 4'($urandom_range(15, 1));
    sensor_hot_pin = 1'b1;
    count_stops(int'(tm1_duty));
    // Monitor disabled while hot: software duty takes charge again
    tm1_enable = 1'b0;
    count_stops(exp_max());
    tm1_enable = 1'b1;
    access(1'b1, SEL_THERM_STATUS, 1'b0, 64'h0);
    access(1'b0, SEL_THERM_STATUS, 1'b0, 64'h0);
    chk("status hot", 64'h3, rd_data);
    sensor_hot_pin = 1'b0;
    access(1'b1, SEL_THERM_STATUS, 1'b0, 64'h3);
    repeat (6) @(negedge clk_sys);
    access(1'b0, SEL_THERM_STATUS, 1'b0, 64'h0);
    chk("status log kept", 64'h2, rd_data);
    count_stops(exp_max());
    access(1'b1, SEL_THERM_STATUS, 1'b0, 64'h0);
    access(1'b0, SEL_THERM_STATUS, 1'b0, 64'h0);
    chk("status log cleared", 64'h0, rd_data);
    agent_hot_pin = 1'b1;
    crit_temp_pin = 1'b1;
    sensor_readout = 7'($urandom);
    repeat (6) @(negedge clk_sys);
    access(1'b0, SEL_THERM_STATUS, 1'b0, 64'h0);
    chk("status pins", {41'h0, sensor_readout, 16'h14}, rd_data);
    finish_test;
  end
endmodule
